//--- hw/mbhp_device_end.sv
// peripheral end of the microcontroller host bus port
`timescale 1ns/10ps
module mbhp_device_end #(
	parameter int SEL_W = mbhp_pkg::SEL_W
) (
	input wire logic clock,
	input wire logic rst_n,
	mbhp_bus_if.device bus,
	input mbhp_pkg::mbhp_c0_mode_t c0_mode,
	input mbhp_pkg::mbhp_c1_mode_t c1_mode,
	input mbhp_pkg::mbhp_c2_mode_t c2_mode,
	input mbhp_pkg::mbhp_as_mode_t as_mode,
	input wire logic multiplexed,
	input wire logic [SEL_W-1:0] block_select,
	input wire logic [7:0] read_low_byte,
	input wire logic [7:0] read_high_byte,
	output logic [15:0] decode_logic_array,
	output logic [15:0] general_logic_array,
	output logic [2:0] control_terms,
	output logic [7:0] write_low_byte,
	output logic [7:0] write_high_byte,
	output logic write_low_pulse,
	output logic write_high_pulse,
	output logic read_active,
	output logic fetch_cycle,
	output logic memories_enabled
);
	// all state in one word; the strobe and write prev bits feed the edge detectors, phase_prev is never used
	typedef struct packed {
		logic [15:0] addr;
		logic as_prev;
		logic phase_prev;
		logic wr_lo_prev;
		logic wr_hi_prev;
		logic [7:0] wdata_lo;
		logic [7:0] wdata_hi;
		logic wl_pulse;
		logic wh_pulse;
	} mbhp_dev_state_t;

	mbhp_dev_state_t state_reg;
	mbhp_dev_state_t state_next;
	// decoded pin terms and lane enables
	logic [15:0] pins;
	logic as_hit;
	logic rd_act;
	logic wr_lo_act;
	logic wr_hi_act;
	logic cs_ok;
	logic high_en;
	logic low_en;
	logic selected;

	// pin word as seen by the decode
	assign pins = {bus.high_byte_bus_port, bus.low_byte_bus_port};

	// chip select low opens memories and I/O, a block must be decoded
	assign cs_ok = !bus.chip_select_n;
	assign selected = cs_ok && (|block_select);

	// byte lane enables from control input two
	always_comb begin
		high_en = 1'b1;
		low_en = 1'b1;
		unique case (c2_mode)
			// high byte taken only while the enable is high
			mbhp_pkg::MBHP_C2_HIGH_ENABLE: high_en = bus.control_input_two;
			// upper strobe and size enable are both active low
			mbhp_pkg::MBHP_C2_HIGH_STROBE_N: high_en = !bus.control_input_two;
			mbhp_pkg::MBHP_C2_SIZE_ENABLE: high_en = !bus.control_input_two;
			// low strobe gates the low lane instead
			mbhp_pkg::MBHP_C2_LOW_STROBE: low_en = !bus.control_input_two;
			// fetch enable leaves both lanes open
			mbhp_pkg::MBHP_C2_FETCH_N: high_en = 1'b1;
			// an illegal role code from outside leaves both lanes open
			default: high_en = 1'b1;
		endcase
	end

	// read qualification from input one, or input two when fetching
	always_comb begin
		rd_act = 1'b0;
		unique case (c1_mode)
			// plain read strobe, active low
			mbhp_pkg::MBHP_C1_READ_N: rd_act = !bus.control_input_one;
			// phase clock high with the read/write line high
			mbhp_pkg::MBHP_C1_PHASE_CLK: rd_act = bus.control_input_one &&
				bus.control_input_zero;
			// data strobes need the read/write line high as well
			mbhp_pkg::MBHP_C1_DATA_STROBE_N: rd_act = !bus.control_input_one &&
				bus.control_input_zero;
			mbhp_pkg::MBHP_C1_LOW_STROBE_N: rd_act = !bus.control_input_one &&
				bus.control_input_zero;
			// an illegal role code reads only through a code fetch on input two
			default: rd_act = 1'b0;
		endcase
		// a code fetch reads as well
		if (c2_mode == mbhp_pkg::MBHP_C2_FETCH_N) begin
			rd_act = rd_act || !bus.control_input_two;
		end
	end

	// write qualification from input zero, lanes from input two
	always_comb begin
		wr_lo_act = 1'b0;
		unique case (c0_mode)
			// plain write strobe and low byte write, both active low
			mbhp_pkg::MBHP_C0_WRITE_N: wr_lo_act = !bus.control_input_zero;
			mbhp_pkg::MBHP_C0_LOW_WRITE_N: wr_lo_act = !bus.control_input_zero;
			// read/write line low, qualified by the phase clock high or else input one low
			mbhp_pkg::MBHP_C0_RD_WR: wr_lo_act = !bus.control_input_zero &&
				(c1_mode == mbhp_pkg::MBHP_C1_PHASE_CLK ?
				bus.control_input_one : !bus.control_input_one);
			// an illegal role code never writes
			default: wr_lo_act = 1'b0;
		endcase
		// separate high write pin in low-write mode, else lane enable
		wr_hi_act = (c0_mode == mbhp_pkg::MBHP_C0_LOW_WRITE_N) ?
			!bus.high_byte_write_n : (wr_lo_act && high_en);
		wr_lo_act = wr_lo_act && low_en;
	end

	// next state: address capture and write strobes
	always_comb begin
		state_next = state_reg;
		// history for edge detection on the strobe and write qualifiers
		state_next.as_prev = bus.address_strobe;
		state_next.wr_lo_prev = wr_lo_act;
		state_next.wr_hi_prev = wr_hi_act;
		state_next.wl_pulse = 1'b0;
		state_next.wh_pulse = 1'b0;
		// latch style follows the strobe level, bus style its rising edge
		as_hit = (as_mode == mbhp_pkg::MBHP_AS_RISE) ?
			(bus.address_strobe && !state_reg.as_prev) :
			bus.address_strobe;
		if (as_hit) begin
			state_next.addr = pins;
		end
		// without a shared bus the address pins are tracked every cycle
		if (!multiplexed) begin
			state_next.addr = pins;
		end
		// write data follows the port while a qualified write stands
		if (wr_lo_act && cs_ok) begin
			state_next.wdata_lo = bus.low_byte_bus_port;
		end
		if (wr_hi_act && cs_ok) begin
			state_next.wdata_hi = bus.high_byte_bus_port;
		end
		// one pulse as the write ends, so the data is complete when used
		state_next.wl_pulse = state_reg.wr_lo_prev && !wr_lo_act && cs_ok;
		state_next.wh_pulse = state_reg.wr_hi_prev && !wr_hi_act && cs_ok;
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs to the logic arrays
	assign decode_logic_array = state_reg.addr;
	assign general_logic_array = state_reg.addr;

	// raw control pins as extra product-term inputs
	assign control_terms = {bus.control_input_two, bus.control_input_one,
		bus.control_input_zero};

	// captured write data and end-of-write pulses
	assign write_low_byte = state_reg.wdata_lo;
	assign write_high_byte = state_reg.wdata_hi;
	assign write_low_pulse = state_reg.wl_pulse;
	assign write_high_pulse = state_reg.wh_pulse;

	// bus activity levels for the memories
	assign read_active = rd_act && selected;
	assign fetch_cycle = (c2_mode == mbhp_pkg::MBHP_C2_FETCH_N) &&
		!bus.control_input_two;
	assign memories_enabled = cs_ok;

	// read drive, floating otherwise
	// lanes are gated apart so a byte strobe can leave one floating
	assign bus.low_byte_dev_out = read_low_byte;
	assign bus.high_byte_dev_out = read_high_byte;
	assign bus.low_byte_dev_oe = rd_act && selected && low_en;
	assign bus.high_byte_dev_oe = rd_act && selected && high_en;
endmodule : mbhp_device_end

//--- hw/mbhp_pkg.sv
// shared constants and types for the host bus port
package mbhp_pkg;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 16;
	localparam int SEL_W = 4;
	localparam int LO_LSB = 0;
	localparam int HI_LSB = 8;
	localparam int BURST_LO_LSB = 4; // burst host data bit 0 sits on line 4
	localparam int BURST_HI_LSB = 12; // burst host data bit 8 on line 12
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// role of control input zero
	typedef enum logic [2:0] {
		MBHP_C0_WRITE_N = 3'h1,
		MBHP_C0_RD_WR = 3'h2,
		MBHP_C0_LOW_WRITE_N = 3'h4
	} mbhp_c0_mode_t;

	// role of control input one
	typedef enum logic [3:0] {
		MBHP_C1_READ_N = 4'h1,
		MBHP_C1_PHASE_CLK = 4'h2,
		MBHP_C1_DATA_STROBE_N = 4'h4,
		MBHP_C1_LOW_STROBE_N = 4'h8
	} mbhp_c1_mode_t;

	// role of control input two
	typedef enum logic [4:0] {
		MBHP_C2_FETCH_N = 5'h01,
		MBHP_C2_HIGH_ENABLE = 5'h02,
		MBHP_C2_HIGH_STROBE_N = 5'h04,
		MBHP_C2_SIZE_ENABLE = 5'h08,
		MBHP_C2_LOW_STROBE = 5'h10
	} mbhp_c2_mode_t;

	// address strobe style
	typedef enum logic [1:0] {
		MBHP_AS_LATCH_HIGH = 2'h1,
		MBHP_AS_RISE = 2'h2
	} mbhp_as_mode_t;
endpackage : mbhp_pkg

//--- hw/mbhp_bus_if.sv
// pins between the microcontroller end and the peripheral end
`timescale 1ns/10ps
interface mbhp_bus_if;
	logic [7:0] low_byte_host_out;
	logic low_byte_host_oe;
	logic [7:0] low_byte_dev_out;
	logic low_byte_dev_oe;
	logic [7:0] high_byte_host_out;
	logic high_byte_host_oe;
	logic [7:0] high_byte_dev_out;
	logic high_byte_dev_oe;
	logic [7:0] low_byte_bus_port;
	logic [7:0] high_byte_bus_port;
	logic address_strobe;
	logic control_input_zero;
	logic control_input_one;
	logic control_input_two;
	logic high_byte_write_n;
	logic chip_select_n;

	// resolved wire level, device wins only while it drives
	assign low_byte_bus_port = low_byte_dev_oe ? low_byte_dev_out :
		low_byte_host_oe ? low_byte_host_out : 8'hFF;
	assign high_byte_bus_port = high_byte_dev_oe ? high_byte_dev_out :
		high_byte_host_oe ? high_byte_host_out : 8'hFF;

	modport device (
		input low_byte_bus_port, high_byte_bus_port, address_strobe,
		input control_input_zero, control_input_one, control_input_two,
		input high_byte_write_n, chip_select_n,
		output low_byte_dev_out, low_byte_dev_oe,
		output high_byte_dev_out, high_byte_dev_oe
	);
	modport host (
		input low_byte_bus_port, high_byte_bus_port,
		output low_byte_host_out, low_byte_host_oe,
		output high_byte_host_out, high_byte_host_oe,
		output address_strobe, control_input_zero, control_input_one,
		output control_input_two, high_byte_write_n, chip_select_n
	);
endinterface : mbhp_bus_if

//--- hw/mbhp_host_end.sv
// microcontroller end: drives address, strobes and write data
`timescale 1ns/10ps
module mbhp_host_end (
	input wire logic clock,
	input wire logic rst_n,
	mbhp_bus_if.host bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_fetch,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic req_ready,
	output logic [15:0] rsp_rdata,
	output logic rsp_valid
);
	typedef enum logic [3:0] {
		MBHP_H_IDLE = 4'h1,
		MBHP_H_ADDR = 4'h2,
		MBHP_H_DATA = 4'h4,
		MBHP_H_DONE = 4'h8
	} mbhp_h_state_t;

	typedef struct packed {
		mbhp_h_state_t st;
		logic wr;
		logic fetch;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic rvalid;
	} mbhp_host_state_t;

	mbhp_host_state_t state_reg;
	mbhp_host_state_t state_next;

	// cycle sequencer: address, data, release
	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		unique case (state_reg.st)
			MBHP_H_IDLE: if (req_valid) begin
				state_next.st = MBHP_H_ADDR;
				state_next.wr = req_write;
				state_next.fetch = req_fetch;
				state_next.addr = req_addr;
				state_next.wdata = req_wdata;
			end
			MBHP_H_ADDR: state_next.st = MBHP_H_DATA;
			MBHP_H_DATA: begin
				state_next.st = MBHP_H_DONE;
				state_next.rdata = {bus.high_byte_bus_port, bus.low_byte_bus_port};
			end
			MBHP_H_DONE: begin
				state_next.st = MBHP_H_IDLE;
				state_next.rvalid = !state_reg.wr;
			end
			default: state_next.st = MBHP_H_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{st: MBHP_H_IDLE, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// pins: write-strobe, read-strobe, fetch style control
	assign bus.address_strobe = (state_reg.st == MBHP_H_ADDR);
	assign bus.control_input_zero = !(state_reg.wr &&
		state_reg.st == MBHP_H_DATA);
	assign bus.control_input_one = !(!state_reg.wr && !state_reg.fetch &&
		state_reg.st == MBHP_H_DATA);
	assign bus.control_input_two = !(state_reg.fetch &&
		state_reg.st == MBHP_H_DATA);
	assign bus.high_byte_write_n = bus.control_input_zero;
	assign bus.chip_select_n = (state_reg.st == MBHP_H_IDLE);
	assign bus.low_byte_host_out = (state_reg.st == MBHP_H_ADDR) ?
		state_reg.addr[7:0] : state_reg.wdata[7:0];
	assign bus.high_byte_host_out = (state_reg.st == MBHP_H_ADDR) ?
		state_reg.addr[15:8] : state_reg.wdata[15:8];
	assign bus.low_byte_host_oe = (state_reg.st == MBHP_H_ADDR) ||
		(state_reg.wr && state_reg.st == MBHP_H_DATA);
	assign bus.high_byte_host_oe = bus.low_byte_host_oe;
	assign req_ready = (state_reg.st == MBHP_H_IDLE);
	assign rsp_rdata = state_reg.rdata;
	assign rsp_valid = state_reg.rvalid;
endmodule : mbhp_host_end

//--- verification/mbhp_checker.sv
// assertions on the pins between the two ends
`timescale 1ns/10ps
module mbhp_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic low_byte_host_oe,
	input wire logic low_byte_dev_oe,
	input wire logic high_byte_host_oe,
	input wire logic high_byte_dev_oe,
	input wire logic address_strobe,
	input wire logic control_input_zero,
	input wire logic control_input_one,
	input wire logic control_input_two,
	input wire logic high_byte_write_n,
	input wire logic chip_select_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// read strobe in either style
	wire logic rd_act = !control_input_one || !control_input_two;
	// address phase, then a read or a write data phase
	sequence addr_ph;
		address_strobe && low_byte_host_oe && high_byte_host_oe;
	endsequence
	sequence rd_cyc;
		addr_ph ##1 rd_act;
	endsequence
	sequence wr_cyc;
		addr_ph ##1 !control_input_zero;
	endsequence
	a_oe_low_read: assert property (low_byte_dev_oe |->
		rd_act && !chip_select_n) else $error("low port driven off read");
	a_oe_high_read: assert property (high_byte_dev_oe |->
		rd_act && !chip_select_n) else $error("high port driven off read");
	a_oe_paired: assert property (low_byte_dev_oe == high_byte_dev_oe)
		else $error("port enables differ");
	a_no_fight: assert property (low_byte_dev_oe |-> !low_byte_host_oe)
		else $error("both ends drive low port");
	a_addr_both: assert property ($rose(address_strobe) |->
		low_byte_host_oe && high_byte_host_oe && !chip_select_n)
		else $error("address not on both ports");
	a_strobe_short: assert property ($rose(address_strobe) |=>
		!address_strobe) else $error("strobe longer than one cycle");
	a_read_release: assert property (rd_cyc |->
		!low_byte_host_oe ##1 !rd_act) else $error("read phase wrong");
	a_write_pair: assert property ($fell(control_input_zero) |->
		!high_byte_write_n && low_byte_host_oe && high_byte_host_oe)
		else $error("write strobes not paired");
	a_write_end: assert property (wr_cyc |=>
		control_input_zero && high_byte_write_n)
		else $error("write strobe not released");
endmodule : mbhp_checker

//--- verification/mcu_bus_host_port_tb.sv
// random reads, fetches and writes across both ends
`timescale 1ns/10ps
module mcu_bus_host_port_tb;
	logic clock = 0;
	logic rst_n = 0;
	logic rv = 0, rw = 0, rf = 0;
	logic [15:0] ra = 16'h0000, rd = 16'h0000, rdata;
	logic rready, rvalid;
	logic [3:0] sel = 4'h0;
	logic [7:0] rlo = 8'h00, rhi = 8'h00, wlo, whi;
	logic [15:0] dla, gla;
	logic [2:0] terms;
	logic wpl, wph, ract, fcyc, men;
	logic [33:0] q[$];
	logic [33:0] note;
	logic saw_rd = 1'b0, saw_fetch = 1'b0;
	int errors = 0, checks_done = 0, cyc = 0, seed = 24172;
	mbhp_bus_if bus ();
	mbhp_host_end u_mbhp_host_end (.clock(clock), .rst_n(rst_n), .bus(bus),
		.req_valid(rv), .req_write(rw), .req_fetch(rf), .req_addr(ra),
		.req_wdata(rd), .req_ready(rready), .rsp_rdata(rdata),
		.rsp_valid(rvalid));
	mbhp_device_end u_mbhp_device_end (.clock(clock), .rst_n(rst_n),
		.bus(bus), .c0_mode(mbhp_pkg::MBHP_C0_WRITE_N),
		.c1_mode(mbhp_pkg::MBHP_C1_READ_N), .c2_mode(mbhp_pkg::MBHP_C2_FETCH_N),
		.as_mode(mbhp_pkg::MBHP_AS_LATCH_HIGH), .multiplexed(1'b1),
		.block_select(sel), .read_low_byte(rlo), .read_high_byte(rhi),
		.decode_logic_array(dla), .general_logic_array(gla),
		.control_terms(terms), .write_low_byte(wlo), .write_high_byte(whi),
		.write_low_pulse(wpl), .write_high_pulse(wph), .read_active(ract),
		.fetch_cycle(fcyc), .memories_enabled(men));
	mbhp_checker u_mbhp_checker (.clock(clock), .rst_n(rst_n),
		.low_byte_host_oe(bus.low_byte_host_oe),
		.low_byte_dev_oe(bus.low_byte_dev_oe),
		.high_byte_host_oe(bus.high_byte_host_oe),
		.high_byte_dev_oe(bus.high_byte_dev_oe),
		.address_strobe(bus.address_strobe),
		.control_input_zero(bus.control_input_zero),
		.control_input_one(bus.control_input_one),
		.control_input_two(bus.control_input_two),
		.high_byte_write_n(bus.high_byte_write_n),
		.chip_select_n(bus.chip_select_n));
	// clock of 20 ns
	always #10 clock = ~clock;
	task automatic check(input string name, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// one transfer; note of {read level, fetch, address, data} is queued
	task automatic xfer(input logic w, f, input logic [3:0] s,
		input logic [15:0] a, d);
		logic [15:0] e;
		e = (w || s != 4'h0) ? d : 16'hFFFF;
		q.push_back({!w && s != 4'h0, f, a, e});
		rv <= 1'b1;
		rw <= w;
		rf <= f;
		ra <= a;
		rd <= d;
		sel <= s;
		rhi <= d[15:8];
		rlo <= d[7:0];
		forever begin
			@(negedge clock);
			if (rready === 1'b1) break;
		end
		@(posedge clock);
		rv <= 1'b0;
		// select and read data stand through address, data and release
		repeat (3) @(posedge clock);
	endtask : xfer
	// results and pin terms seen where settled
	always @(negedge clock) begin
		if (rst_n) begin
			check("arrays", {16'h0000, gla}, {16'h0000, dla});
			check("terms", {29'h0, terms}, {29'h0, bus.control_input_two,
				bus.control_input_one, bus.control_input_zero});
			check("mem_en", {31'h0, men}, {31'h0, !bus.chip_select_n});
			saw_rd = saw_rd || ract === 1'b1;
			saw_fetch = saw_fetch || fcyc === 1'b1;
			if (rvalid === 1'b1) begin
				note = q.pop_front();
				check("read", {dla, rdata}, note[31:0]);
				check("read_act", 32'(saw_rd), 32'(note[33]));
				check("fetch", 32'(saw_fetch), 32'(note[32]));
			end
			if (wpl === 1'b1) begin
				note = q.pop_front();
				check("write", {dla, whi, wlo}, note[31:0]);
				check("write_high", 32'(wph), 32'h1);
				check("write_act", 32'(saw_rd), 32'(note[33]));
			end
			if (rvalid === 1'b1 || wpl === 1'b1) begin
				saw_rd = 1'b0;
				saw_fetch = 1'b0;
			end
		end
	end
	// hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		logic w;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			w = $random(seed) % 3 == 0;
			xfer(w, !w && i[0], (i % 5 == 1) ? 4'h0 : 4'($random(seed)),
				16'($random(seed)), 16'($random(seed)));
		end
		repeat (8) @(posedge clock);
		check("pending", 32'(q.size()), 32'h0);
		end_sim();
	end
endmodule : mcu_bus_host_port_tb
